// *** hw/led_display_pkg.sv ***
// Constants shared by the LED capacity display and its bank timer
package led_display_pkg;

    // ************************************************
    // Timebase
    // ************************************************
    localparam int CLK_HZ         = 40_000_000;
    localparam int MUX_HZ         = 100;
    localparam int BANK_ON_PCT    = 30;
    localparam int BLINK_HZ       = 4;
    localparam int MUX_PERIOD_CYC = CLK_HZ / MUX_HZ;
    localparam int BANK_ON_CYC    = MUX_PERIOD_CYC * BANK_ON_PCT / 100;
    localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);

    // ************************************************
    // Widths and segment layout
    // ************************************************
    localparam int CHARGE_W = 16;
    localparam int SEG_N    = 6;
    localparam int FIFTHS   = 5;
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 16;
    localparam int SCALE_W  = 5;
    localparam int SCALE_SH = 4;
    localparam logic [SEG_N-1:0] ODD_BANK_MASK  = 6'h15;
    localparam logic [SEG_N-1:0] EVEN_BANK_MASK = 6'h2a;

    // ************************************************
    // Register map and reset values
    // ************************************************
    localparam logic [ADDR_W-1:0] REG_CTRL       = 4'h0;
    localparam logic [ADDR_W-1:0] REG_THRESH     = 4'h1;
    localparam logic [ADDR_W-1:0] REG_LEARNED    = 4'h2;
    localparam logic [ADDR_W-1:0] REG_STATUS     = 4'h3;
    localparam logic [ADDR_W-1:0] REG_PROGRAMMED = 4'h4;
    localparam int                CTRL_ABS_BIT   = 0;
    localparam logic [DATA_W-1:0] CTRL_RESET     = 16'h0000;
    localparam logic [DATA_W-1:0] THRESH_RESET   = 16'h0177;
    localparam logic signed [DATA_W-1:0] DISCHARGE_LIMIT_UV = -16'sh0fa0;

    typedef enum logic [1:0] {SHOW_OFF, SHOW_ALWAYS, SHOW_ACTIVITY} show_mode_e;

endpackage

// *** hw/bank_timer.sv ***
// Bank alternation, duty window and low-battery blink timebase
`timescale 1ns/10ps
module bank_timer #(
    parameter int PERIOD_CYC = led_display_pkg::MUX_PERIOD_CYC,
    parameter int ON_CYC     = led_display_pkg::BANK_ON_CYC,
    parameter int BLINK_CYC  = led_display_pkg::BLINK_HALF_CYC
) (
    input  wire logic clk_i,      // System clock
    input  wire logic sys_rst_i,  // Synchronous reset
    input  wire logic ce_i,       // Clock enable
    output logic      odd_on_o,   // Odd bank window
    output logic      even_on_o,  // Even bank window
    output logic      blink_o     // Blink phase
);
    import led_display_pkg::*;

    localparam int PW = $clog2(PERIOD_CYC);
    localparam int BW = $clog2(BLINK_CYC);
    localparam logic [PW-1:0] HALF = PW'(PERIOD_CYC / 2);

    if (ON_CYC < 1 || 2 * ON_CYC > PERIOD_CYC || BLINK_CYC < 2)
        $error("bank_timer: windows overlap or counts too small");

    logic [PW-1:0] period_cnt;
    logic [PW-1:0] next_period_cnt;
    logic [BW-1:0] blink_cnt;
    logic [BW-1:0] next_blink_cnt;
    logic          next_odd_on;
    logic          next_even_on;
    logic          next_blink;

    // ************************************************
    // Counters
    // ************************************************
    always_comb
    begin
        next_period_cnt = (period_cnt == PW'(PERIOD_CYC - 1)) ? '0 : period_cnt + 1'b1;
        next_blink_cnt  = (blink_cnt == BW'(BLINK_CYC - 1)) ? '0 : blink_cnt + 1'b1;
        next_blink      = (blink_cnt == BW'(BLINK_CYC - 1)) ? ~blink_o : blink_o;
        // Windows sit half a period apart, so the banks never overlap
        next_odd_on     = next_period_cnt < PW'(ON_CYC);
        next_even_on    = next_period_cnt >= HALF && next_period_cnt < HALF + PW'(ON_CYC);
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            period_cnt <= '0;
            blink_cnt  <= '0;
            odd_on_o   <= 1'b1;  // Count 0 sits inside the odd window
            even_on_o  <= 1'b0;
            blink_o    <= 1'b0;
        end
        else if (ce_i)
        begin
            period_cnt <= next_period_cnt;
            blink_cnt  <= next_blink_cnt;
            odd_on_o   <= next_odd_on;
            even_on_o  <= next_even_on;
            blink_o    <= next_blink;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    logic [PW-1:0] odd_run;
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            odd_run <= '0;
        else if (ce_i)
            odd_run <= odd_on_o ? odd_run + 1'b1 : '0;
    end

    a_banks_exclusive: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !(odd_on_o && even_on_o)) else $error("both banks enabled");
    a_duty_length: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        odd_on_o && ce_i && !next_odd_on |-> odd_run == PW'(ON_CYC - 1)) else $error("odd window length wrong");
    a_blink_rate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $changed(blink_o) |-> $past(blink_cnt) == BW'(BLINK_CYC - 1)) else $error("blink toggled off schedule");

endmodule // bank_timer

// *** hw/led_capacity_display.sv ***
// Six-segment LED capacity bar driven from the gas-gauge counters
//
// Behaviour
// - Relative mode: fifths of learned capacity, no sixth
// - Absolute mode: fifths of programmed count, overfull sixth
// - Absolute mode: worn battery lights fewer segments when full
// - Temperature scales display, counter left untouched
// - Request pin high keeps segments dark
// - Floating pin: display while sense voltage shows charge or discharge
// - Request pin low lights display at once
// - Two banks of three, never together
// - Banks alternate near 100Hz, 30% each
// - First empty warning blinks segment 1 at 4Hz
// - Final empty warning blanks the whole display
// - Reset loads learned capacity from programmed count
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module led_capacity_display #(
    parameter int PERIOD_CYC = led_display_pkg::MUX_PERIOD_CYC,
    parameter int ON_CYC     = led_display_pkg::BANK_ON_CYC,
    parameter int BLINK_CYC  = led_display_pkg::BLINK_HALF_CYC
) (
    input  wire logic                                       clk_i,                        // 40 MHz clock
    input  wire logic                                       sys_rst_i,                    // Synchronous reset
    input  wire logic                                       ce_i,                         // Clock enable
    input  wire logic [led_display_pkg::ADDR_W-1:0]         addr_i,                       // Register address
    input  wire logic [led_display_pkg::DATA_W-1:0]         wdata_i,                      // Write data
    input  wire logic                                       we_i,                         // Write strobe
    input  wire logic                                       re_i,                         // Read strobe
    output logic      [led_display_pkg::DATA_W-1:0]         rdata_o,                      // Read data
    input  wire logic [led_display_pkg::CHARGE_W-1:0]       available_charge_counter_i,   // Gauge charge count
    input  wire logic [led_display_pkg::CHARGE_W-1:0]       programmed_full_count_i,      // Strapped full count
    input  wire logic                                       learn_update_i,               // Gauge relearn strobe
    input  wire logic [led_display_pkg::CHARGE_W-1:0]       learn_value_i,                // Relearned capacity
    input  wire logic [3:0]                                 temperature_gauge_reg_i,      // Temperature step
    input  wire logic signed [led_display_pkg::DATA_W-1:0]  sense_input_voltage_i,        // Sense voltage, uV
    input  wire logic                                       first_empty_warning_i,        // Low battery flag
    input  wire logic                                       final_empty_warning_i,        // Empty battery flag
    input  wire logic                                       display_request_high_i,       // Pin at supply
    input  wire logic                                       display_request_low_i,        // Pin pulled low
    output logic      [led_display_pkg::SEG_N-1:0]          led_segment_outputs_o,        // Segment drives
    output logic                                            led_common_drive_o            // LED common drive
);
    import led_display_pkg::*;

    localparam int PW = CHARGE_W + 3;

    // ************************************************
    // Helpers
    // ************************************************
    // Sixteenths of nominal charge usable at each temperature step
    function automatic logic [SCALE_W-1:0] temp_scale(input logic [3:0] code);
        unique case (code)
            4'h0, 4'h1: temp_scale = 5'h08;
            4'h2:       temp_scale = 5'h0a;
            4'h3:       temp_scale = 5'h0c;
            default:    temp_scale = 5'h10;
        endcase
    endfunction

    // Thermometer of fifths: segment k lit once charge reaches k-1 fifths
    function automatic logic [FIFTHS-1:0] seg_level(input logic [CHARGE_W-1:0] chg,
                                                   input logic [CHARGE_W-1:0] full);
        logic [PW-1:0] chg5;
        chg5 = PW'(chg) * PW'(FIFTHS);
        for (int k = 0; k < FIFTHS; k++)
            seg_level[k] = chg5 >= PW'(full) * PW'(k);
    endfunction

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic pin_high_meta;
    logic pin_high_sync;
    logic pin_low_meta;
    logic pin_low_sync;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pin_high_meta <= 1'b0;
            pin_high_sync <= 1'b0;
            pin_low_meta  <= 1'b0;
            pin_low_sync  <= 1'b0;
        end
        else if (ce_i)
        begin
            pin_high_meta <= display_request_high_i;
            pin_high_sync <= pin_high_meta;
            pin_low_meta  <= display_request_low_i;
            pin_low_sync  <= pin_low_meta;
        end
    end

    // ************************************************
    // Registers
    // ************************************************
    logic [DATA_W-1:0]   ctrl;
    logic [DATA_W-1:0]   thresh;
    logic [CHARGE_W-1:0] learned_full_capacity;
    logic [CHARGE_W-1:0] programmed_full_count;
    logic [DATA_W-1:0]   next_ctrl;
    logic [DATA_W-1:0]   next_thresh;
    logic [CHARGE_W-1:0] next_learned;
    logic [DATA_W-1:0]   next_rdata;
    logic [DATA_W-1:0]   status_word;
    logic                display_on;
    logic                activity;
    logic                abs_mode;
    logic                odd_on;
    logic                even_on;
    logic                blink;

    assign abs_mode = ctrl[CTRL_ABS_BIT];

    always_comb
    begin
        next_ctrl    = ctrl;
        next_thresh  = thresh;
        next_learned = learned_full_capacity;
        next_rdata   = '0;
        if (we_i)
        begin
            unique case (addr_i)
                REG_CTRL:    next_ctrl    = wdata_i & 16'h0001;
                REG_THRESH:  next_thresh  = wdata_i;
                REG_LEARNED: next_learned = wdata_i;
                default:     ;
            endcase
        end
        // The gauge's own relearn wins over a software write in the same cycle
        if (learn_update_i)
            next_learned = learn_value_i;
        if (re_i)
        begin
            unique case (addr_i)
                REG_CTRL:       next_rdata = ctrl;
                REG_THRESH:     next_rdata = thresh;
                REG_LEARNED:    next_rdata = learned_full_capacity;
                REG_STATUS:     next_rdata = status_word;
                REG_PROGRAMMED: next_rdata = programmed_full_count;
                default:        next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            ctrl                  <= CTRL_RESET;
            thresh                <= THRESH_RESET;
            // Strap is read only in reset; a changed strap needs a new reset
            programmed_full_count <= programmed_full_count_i;
            learned_full_capacity <= programmed_full_count_i;
            rdata_o               <= '0;
        end
        else if (ce_i)
        begin
            ctrl                  <= next_ctrl;
            thresh                <= next_thresh;
            learned_full_capacity <= next_learned;
            rdata_o               <= next_rdata;
        end
    end

    // ************************************************
    // Capacity scaling
    // ************************************************
    logic [CHARGE_W-1:0]         capped;
    logic [CHARGE_W+SCALE_W-1:0] scaled;
    logic [CHARGE_W-1:0]         adj_charge;
    logic [CHARGE_W-1:0]         scale_ref;
    logic [FIFTHS-1:0]           level;
    logic                        overfull;
    logic [SEG_N-1:0]            lit;

    always_comb
    begin
        // Charge never shows above what the pack really holds
        capped     = (available_charge_counter_i > learned_full_capacity) ?
                     learned_full_capacity : available_charge_counter_i;
        scaled     = (CHARGE_W+SCALE_W)'(capped) * (CHARGE_W+SCALE_W)'(temp_scale(temperature_gauge_reg_i));
        adj_charge = scaled[CHARGE_W+SCALE_SH-1:SCALE_SH];
        scale_ref  = abs_mode ? programmed_full_count : learned_full_capacity;
        level      = seg_level(adj_charge, scale_ref);
        overfull   = abs_mode && (adj_charge > programmed_full_count);
        lit        = {overfull, level};
        lit[0]     = level[0] && (!first_empty_warning_i || blink);
    end

    // ************************************************
    // Display request decode
    // ************************************************
    show_mode_e show_mode;

    always_comb
    begin
        // Supply level wins if both pin levels read high
        if (pin_high_sync)
            show_mode = SHOW_OFF;
        else if (pin_low_sync)
            show_mode = SHOW_ALWAYS;
        else
            show_mode = SHOW_ACTIVITY;
        activity = (sense_input_voltage_i < DISCHARGE_LIMIT_UV) ||
                   (sense_input_voltage_i > $signed(thresh));
        unique case (show_mode)
            SHOW_OFF:      display_on = 1'b0;
            SHOW_ALWAYS:   display_on = 1'b1;
            SHOW_ACTIVITY: display_on = activity;
        endcase
        if (final_empty_warning_i)
            display_on = 1'b0;
    end

    // ************************************************
    // Bank multiplexing
    // ************************************************
    logic [SEG_N-1:0] next_segments;
    logic             next_common;

    bank_timer #(
        .PERIOD_CYC (PERIOD_CYC),
        .ON_CYC     (ON_CYC),
        .BLINK_CYC  (BLINK_CYC)
    ) u_bank_timer (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .ce_i       (ce_i),
        .odd_on_o   (odd_on),
        .even_on_o  (even_on),
        .blink_o    (blink)
    );

    always_comb
    begin
        next_segments = '0;
        if (display_on && odd_on)
            next_segments = lit & ODD_BANK_MASK;
        else if (display_on && even_on)
            next_segments = lit & EVEN_BANK_MASK;
        next_common = display_on && (odd_on || even_on);
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            led_segment_outputs_o <= '0;
            led_common_drive_o    <= 1'b0;
        end
        else if (ce_i)
        begin
            led_segment_outputs_o <= next_segments;
            led_common_drive_o    <= next_common;
        end
    end

    assign status_word = {5'h00, blink, even_on, odd_on, activity, display_on, led_segment_outputs_o};

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_odd_slot;
        ce_i && odd_on && !first_empty_warning_i && !final_empty_warning_i;
    endsequence

    sequence s_seg1_lit;
        ##1 led_segment_outputs_o[0] && led_common_drive_o;
    endsequence

    a_high_pin_dark: assert property (ce_i && pin_high_sync |=> led_segment_outputs_o == '0)
        else $error("segments lit with request pin high");
    a_final_blank: assert property (ce_i && final_empty_warning_i
        |=> led_segment_outputs_o == '0 && !led_common_drive_o) else $error("display active at final empty");
    a_no_sixth_rel: assert property (ce_i && !abs_mode |=> !led_segment_outputs_o[5])
        else $error("sixth segment lit in relative mode");
    a_banks_apart: assert property (!(|(led_segment_outputs_o & ODD_BANK_MASK) &&
        |(led_segment_outputs_o & EVEN_BANK_MASK))) else $error("both banks driven");
    a_low_pin_on: assert property (s_odd_slot ##0 (pin_low_sync && !pin_high_sync) |-> s_seg1_lit)
        else $error("low request pin did not light display");
    a_activity_on: assert property (s_odd_slot ##0 (!pin_low_sync && !pin_high_sync &&
        (sense_input_voltage_i < DISCHARGE_LIMIT_UV || sense_input_voltage_i > $signed(thresh))) |-> s_seg1_lit)
        else $error("charge activity did not light display");
    a_overfull_seg: assert property (ce_i && display_on && even_on && abs_mode &&
        adj_charge > programmed_full_count |=> led_segment_outputs_o[5]) else $error("overfull not shown");
    a_blink_dark: assert property (ce_i && display_on && odd_on && first_empty_warning_i && !blink
        |=> !led_segment_outputs_o[0]) else $error("segment 1 not blinking");
    a_learned_reset: assert property (@(posedge clk_i) $fell(sys_rst_i)
        |-> learned_full_capacity == $past(programmed_full_count_i)) else $error("learned capacity not loaded");
    // Common must follow the windows, or a dark bank still draws current
    a_common_window: assert property (ce_i && !odd_on && !even_on |=> !led_common_drive_o)
        else $error("common driven outside bank window");
    a_odd_only: assert property (ce_i && odd_on |=> (led_segment_outputs_o & EVEN_BANK_MASK) == '0)
        else $error("even segment in odd window");
    a_blink_lit: assert property (ce_i && display_on && odd_on && first_empty_warning_i && blink
        |=> led_segment_outputs_o[0]) else $error("segment 1 dark in blink phase");

endmodule // led_capacity_display

// *** testbench/led_panel_model.sv ***
// Behavioural LED panel and display-request pin facing the capacity display
`timescale 1ns/10ps
module led_panel_model
    import led_display_pkg::*;
(
    input  wire logic       clk_i,        // System clock
    input  wire logic [1:0] pin_mode_i,   // 0 float, 1 supply, 2 pulled low
    input  wire logic [5:0] segment_i,    // Segment drives
    input  wire logic       common_i,     // Common drive
    input  wire logic       clear_i,      // Restart observation
    output logic            pin_high_o,   // Pin at supply
    output logic            pin_low_o,    // Pin pulled low
    output logic [5:0]      lit_seen_o,   // Segments seen lit
    output int              common_cyc_o, // Cycles with common high
    output int              odd_cyc_o,    // Cycles odd bank lit
    output int              even_cyc_o,   // Cycles even bank lit
    output int              seg1_cyc_o,   // Cycles segment 1 lit
    output logic            clash_o       // Both banks lit at once
);
    logic odd_lit;
    logic even_lit;

    // Floating pin: neither level is seen
    assign pin_high_o = (pin_mode_i == 2'h1);
    assign pin_low_o  = (pin_mode_i == 2'h2);
    // An LED only glows while its common is driven
    assign odd_lit    = common_i && ((segment_i & ODD_BANK_MASK) != 6'h00);
    assign even_lit   = common_i && ((segment_i & EVEN_BANK_MASK) != 6'h00);

    always_ff @(posedge clk_i)
    begin
        if (clear_i)
        begin
            lit_seen_o   <= 6'h00;
            common_cyc_o <= 0;
            odd_cyc_o    <= 0;
            even_cyc_o   <= 0;
            seg1_cyc_o   <= 0;
            clash_o      <= 1'b0;
        end
        else
        begin
            lit_seen_o   <= lit_seen_o | (segment_i & {6{common_i}});
            common_cyc_o <= common_cyc_o + int'(common_i);
            odd_cyc_o    <= odd_cyc_o + int'(odd_lit);
            even_cyc_o   <= even_cyc_o + int'(even_lit);
            seg1_cyc_o   <= seg1_cyc_o + int'(common_i && segment_i[0]);
            clash_o      <= clash_o | (odd_lit && even_lit);
        end
    end
endmodule // led_panel_model

// *** testbench/led_capacity_display_tb.sv ***
// Self-checking bench for the LED capacity display
`timescale 1ns/10ps
module led_capacity_display_tb;
    import led_display_pkg::*;
    localparam int WIN = 6;
    logic clk = 1'b0, sys_rst = 1'b1, we = 1'b0, re = 1'b0, clear = 1'b0, ce = 1'b1;
    logic lrn_upd = 1'b0, first_warn = 1'b0, final_warn = 1'b0, pin_high, pin_low, com, clash;
    logic [3:0] addr = 4'h0, temp = 4'hf;
    logic [1:0] pin_mode = 2'h2;
    logic [15:0] wdata = 16'h0000, rdata, charge = 16'h03e8, prog = 16'h03e8, lrn_val = 16'h0000;
    logic signed [15:0] sense = 16'sh0000;
    logic [5:0] seg, lit_seen;
    int com_cyc, odd_cyc, even_cyc, seg1_cyc, bad_count = 0, comparisons = 0;

    always #12.5 clk = ~clk;

    led_capacity_display #(.PERIOD_CYC(20), .ON_CYC(WIN), .BLINK_CYC(8)) i_led_capacity_display (
        .clk_i(clk), .sys_rst_i(sys_rst), .ce_i(ce), .addr_i(addr), .wdata_i(wdata), .we_i(we),
        .re_i(re), .rdata_o(rdata), .available_charge_counter_i(charge), .programmed_full_count_i(prog),
        .learn_update_i(lrn_upd), .learn_value_i(lrn_val), .temperature_gauge_reg_i(temp),
        .sense_input_voltage_i(sense), .first_empty_warning_i(first_warn), .final_empty_warning_i(final_warn),
        .display_request_high_i(pin_high), .display_request_low_i(pin_low),
        .led_segment_outputs_o(seg), .led_common_drive_o(com));

    led_panel_model i_led_panel_model (
        .clk_i(clk), .pin_mode_i(pin_mode), .segment_i(seg), .common_i(com), .clear_i(clear),
        .pin_high_o(pin_high), .pin_low_o(pin_low), .lit_seen_o(lit_seen), .common_cyc_o(com_cyc),
        .odd_cyc_o(odd_cyc), .even_cyc_o(even_cyc), .seg1_cyc_o(seg1_cyc), .clash_o(clash));

    // ************************************************
    // Shared tasks
    // ************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("mismatches %0d of %0d comparisons", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        we    <= 1'b1;
        @(posedge clk);
        we    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        re   <= 1'b1;
        @(posedge clk);
        re   <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask

    // Expected bar: clamp to learned, temperature scale, fifths of the reference
    function automatic logic [5:0] exp_mask(int q, int lrn, int prg, int t, bit absm);
        int sc, adj, rf;
        exp_mask = 6'h00;
        sc = (t < 2) ? 8 : (t == 2) ? 10 : (t == 3) ? 12 : 16;
        adj = ((q < lrn) ? q : lrn) * sc / 16;
        rf = absm ? prg : lrn;
        for (int k = 0; k < 5; k++)
            exp_mask[k] = (5 * adj >= k * rf);
        exp_mask[5] = absm && (adj > prg);
    endfunction

    task automatic observe(input int n);
        @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // Two mux periods: every segment gets its window
    task automatic look(input logic [5:0] exp);
        repeat (4) @(posedge clk);
        observe(40);
        chk({10'h000, lit_seen}, {10'h000, exp});
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic regs_after_reset();
        rd(REG_CTRL, CTRL_RESET);
        rd(REG_THRESH, THRESH_RESET);
        rd(REG_LEARNED, 16'h03e8);
        wr(REG_PROGRAMMED, 16'h1234);
        rd(REG_PROGRAMMED, 16'h03e8);
        rd(4'hf, 16'h0000);
    endtask

    task automatic relative_scale();
        int q [8] = '{0, 199, 200, 399, 400, 800, 1000, 1200};
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            charge <= 16'(q[i]);
            look(exp_mask(q[i], 1000, 1000, 15, 1'b0));
        end
    endtask

    task automatic absolute_scale();
        int q [3] = '{1000, 1001, 1500};
        wr(REG_LEARNED, 16'h07d0);
        wr(REG_CTRL, 16'h0001);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk);
            charge <= 16'(q[i]);
            look(exp_mask(q[i], 2000, 1000, 15, 1'b1));
        end
        wr(REG_LEARNED, 16'h0258);
        charge <= 16'h03e8;
        look(exp_mask(1000, 600, 1000, 15, 1'b1));
        wr(REG_CTRL, 16'h0000);
        look(exp_mask(1000, 600, 1000, 15, 1'b0));
    endtask

    task automatic temperature_scale();
        wr(REG_LEARNED, 16'h03e8);
        for (int t = 0; t < 16; t++)
        begin
            @(posedge clk);
            temp <= 4'(t);
            look(exp_mask(1000, 1000, 1000, t, 1'b0));
        end
    endtask

    task automatic request_pin();
        int sv [4] = '{-4001, -4000, 375, 376};
        @(posedge clk);
        pin_mode <= 2'h1;
        sense    <= -16'sh1388;
        look(6'h00);
        @(posedge clk);
        pin_mode <= 2'h0;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            sense <= 16'(sv[i]);
            look((i == 0 || i == 3) ? 6'h1f : 6'h00);
        end
        @(posedge clk);
        sense    <= 16'sh0000;
        pin_mode <= 2'h2;
        look(6'h1f);
    endtask

    task automatic bank_timing();
        observe(80);
        chk(16'(odd_cyc), 16'(4 * WIN));
        chk(16'(even_cyc), 16'(4 * WIN));
        chk(16'(com_cyc), 16'(8 * WIN));
        chk({15'h0000, clash}, 16'h0000);
        // Frozen enable: common may not move at all
        @(posedge clk);
        ce <= 1'b0;
        observe(20);
        chk({15'h0000, com_cyc == 0 || com_cyc == 20}, 16'h0001);
        @(posedge clk);
        ce <= 1'b1;
    endtask

    task automatic warnings();
        @(posedge clk);
        first_warn <= 1'b1;
        repeat (4) @(posedge clk);
        observe(80);
        chk({15'h0000, seg1_cyc > 0 && seg1_cyc < 4 * WIN}, 16'h0001);
        chk(16'(odd_cyc), 16'(4 * WIN));
        @(posedge clk);
        first_warn <= 1'b0;
        final_warn <= 1'b1;
        look(6'h00);
        @(posedge clk);
        final_warn <= 1'b0;
    endtask

    task automatic second_reset();
        @(posedge clk);
        prog    <= 16'h0320;
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({9'h000, com, seg}, 16'h0000);
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rd(REG_LEARNED, 16'h0320);
        @(posedge clk);
        lrn_val <= 16'h0384;
        lrn_upd <= 1'b1;
        @(posedge clk);
        lrn_upd <= 1'b0;
        rd(REG_LEARNED, 16'h0384);
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        regs_after_reset();
        relative_scale();
        absolute_scale();
        temperature_scale();
        request_pin();
        bank_timing();
        warnings();
        second_reset();
        conclude();
    end

    // Whole run is about two thousand cycles
    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule // led_capacity_display_tb
